// ---- logic/adc_link_pkg.sv ----
// Shared constants for the dual-channel converter link and its controller
// Functional notes
// - Mark channel-A results during multichannel operation
// - Bits ten and eleven select register on writes
// - Twelve-bit tristate bus, bit zero least significant
// - Hardware reset restores control register defaults
// - Read strobe honoured only in write-only mode
// - Write pin is direction or write-only strobe
// - Host makes a configuring write its first access
// - Start conversion on each conversion clock fall
// - Result appears five conversion cycles later
// - First marker delayed seven plus channel count
// - Per-channel rate is aggregate over channel count
// - Reference is internal or external by configuration
// - Inputs sampled together, selectable, single or differential
// - Conversion clock free-running with even duty
// - Select needs low select low, high select high
// - Far party drives the conversion clock
package adc_link_pkg;
  localparam int DATA_W = 12;
  localparam int CFG_W = 10;
  localparam int SEL_LSB = 10;
  localparam int SEL_MSB = 11;
  localparam logic [1:0] SEL_CR0 = 2'h0;
  localparam logic [1:0] SEL_CR1 = 2'h1;
  localparam logic [CFG_W-1:0] CR0_RESET = 10'h000;
  localparam logic [CFG_W-1:0] CR1_RESET = 10'h000;
  localparam int CR0_VREF = 0;
  localparam int CR0_PD = 2;
  localparam int CR0_CHSEL0 = 3;
  localparam int CR0_DIFF0 = 5;
  localparam int CR0_SCAN = 7;
  localparam int CR1_SWRESET = 0;
  localparam int CR1_SRST = 1;
  localparam int CR1_WR_ONLY = 6;
  localparam int CR1_TWOS = 7;
  localparam int PIPE_DEPTH = 5;
  localparam logic [3:0] SYNC_BASE = 4'h7;
  localparam logic [3:0] ONE_CH = 4'h1;
  localparam logic [3:0] TWO_CH = 4'h2;
  localparam logic [12:0] DIFF_ONE = 13'h0001;
  localparam int CLK_NS = 50;
  localparam int CONV_HALF_NS = 100;
  localparam int STROBE_NS = 150;
  localparam logic [2:0] CONV_HALF_CNT =
    3'((CONV_HALF_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [2:0] STROBE_CNT = 3'((STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [2:0] CNT_ONE = 3'h1;
  localparam logic [7:0] OFS_WRITE = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_READ = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_DATA = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int MODE_WO = 0;
  localparam int MODE_HWRST = 1;
endpackage

// ---- logic/adc_link_if.sv ----
// Parallel link between converter and its host controller
`timescale 1ns/1ps
interface adc_link_if;
  import adc_link_pkg::*;
  logic conversion_clock;
  logic sel_low_n;
  logic sel_high;
  logic rd_n;
  logic wr_n;
  logic hw_reset_n;
  logic sync_n;
  logic [DATA_W-1:0] dev_d;
  logic [DATA_W-1:0] host_d;
  logic [DATA_W-1:0] bus;
  logic dev_oe;
  logic host_oe;
  // Undriven bus reads as zero
  assign bus = dev_oe ? dev_d : (host_oe ? host_d : '0);
  modport dev (
    input conversion_clock, sel_low_n, sel_high, rd_n, wr_n, hw_reset_n, bus,
    output dev_d, dev_oe, sync_n
  );
  modport host (
    input bus, sync_n,
    output conversion_clock, sel_low_n, sel_high, rd_n, wr_n, hw_reset_n,
    output host_d, host_oe
  );
endinterface

// ---- logic/adc_dev.sv ----
// Converter end: control registers, strobe decode, pipeline and marker
`timescale 1ns/1ps
module adc_dev
  import adc_link_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  adc_link_if.dev LINK,
  input wire logic [DATA_W-1:0] SAMPLE_A_I,
  input wire logic [DATA_W-1:0] SAMPLE_B_I,
  output logic REF_EXT_O,
  output logic POWER_DOWN_O,
  output logic DIFF_MODE_O,
  output logic TWO_CH_O
);
  logic [CFG_W-1:0] cr0_reg;
  logic [CFG_W-1:0] cr1_reg;
  logic wr_prev_reg;
  logic [DATA_W-1:0] wr_data_reg;
  logic conv_prev_reg;
  logic chan_b_reg;
  logic [DATA_W-1:0] held_b_reg;
  logic [DATA_W-1:0] pipe_d_reg [PIPE_DEPTH];
  logic pipe_a_reg [PIPE_DEPTH];
  logic [DATA_W-1:0] out_d_reg;
  logic out_a_reg;
  logic [3:0] hold_reg;
  logic sync_n_reg;
  logic dev_oe_reg;
  logic [DATA_W-1:0] dev_d_reg;
  logic sel;
  logic wr_only;
  logic wr_act;
  logic rd_act;
  logic commit;
  logic srst_evt;
  logic two_ch;
  logic fall;
  logic [DATA_W-1:0] new_code;
  logic [12:0] diff_sum;

  // Offset binary becomes twos complement by flipping the top bit
  function automatic logic [DATA_W-1:0] fmt(input logic [DATA_W-1:0] x,
                                            input logic twos);
    fmt = twos ? {~x[DATA_W-1], x[DATA_W-2:0]} : x;
  endfunction

  // Access decode from both selects
  assign sel = ~LINK.sel_low_n & LINK.sel_high;
  assign wr_only = cr1_reg[CR1_WR_ONLY];
  assign wr_act = sel & ~LINK.wr_n;
  assign rd_act = wr_only ? (sel & LINK.wr_n & ~LINK.rd_n) : (sel & LINK.wr_n);
  // Register commits when the write strobe ends, data from its last cycle
  assign commit = wr_prev_reg & ~wr_act;
  assign srst_evt = commit && wr_data_reg[SEL_MSB:SEL_LSB] == SEL_CR1 &&
                    wr_data_reg[CR1_SRST];
  assign two_ch = cr0_reg[CR0_SCAN] & ~cr0_reg[CR0_DIFF0];
  assign fall = conv_prev_reg & ~LINK.conversion_clock;
  // Differential code: (a - b) / 2 around mid scale
  assign diff_sum = 13'({1'b0, SAMPLE_A_I}) + 13'({1'b0, ~SAMPLE_B_I}) +
                    DIFF_ONE;

  always_comb
  begin
    if (two_ch)
      new_code = chan_b_reg ? held_b_reg : SAMPLE_A_I;
    else if (cr0_reg[CR0_DIFF0])
      new_code = diff_sum[12:1];
    else if (cr0_reg[CR0_CHSEL0])
      new_code = SAMPLE_B_I;
    else
      new_code = SAMPLE_A_I;
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      wr_prev_reg <= 1'b0;
      wr_data_reg <= '0;
    end
    else
    begin
      wr_prev_reg <= wr_act;
      if (wr_act)
        wr_data_reg <= LINK.bus;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      cr0_reg <= CR0_RESET;
      cr1_reg <= CR1_RESET;
    end
    else if (!LINK.hw_reset_n)
    begin
      cr0_reg <= CR0_RESET;
      cr1_reg <= CR1_RESET;
    end
    else if (commit)
    begin
      if (wr_data_reg[SEL_MSB:SEL_LSB] == SEL_CR0)
        cr0_reg <= wr_data_reg[CFG_W-1:0];
      else if (wr_data_reg[SEL_MSB:SEL_LSB] == SEL_CR1)
      begin
        // Software reset bit is not stored, it restores both registers
        if (wr_data_reg[CR1_SWRESET])
        begin
          cr0_reg <= CR0_RESET;
          cr1_reg <= CR1_RESET;
        end
        else
          cr1_reg <= wr_data_reg[CFG_W-1:0];
      end
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      conv_prev_reg <= 1'b0;
      chan_b_reg <= 1'b0;
      held_b_reg <= '0;
      out_d_reg <= '0;
      out_a_reg <= 1'b0;
      for (int i = 0; i < PIPE_DEPTH; i++)
      begin
        pipe_d_reg[i] <= '0;
        pipe_a_reg[i] <= 1'b0;
      end
    end
    else
    begin
      conv_prev_reg <= LINK.conversion_clock;
      if (srst_evt || !LINK.hw_reset_n)
        chan_b_reg <= 1'b0;
      else if (fall && !cr0_reg[CR0_PD])
      begin
        // Alternate slots share the aggregate rate
        chan_b_reg <= two_ch & ~chan_b_reg;
        // Channel B held from the channel A instant
        if (!chan_b_reg)
          held_b_reg <= SAMPLE_B_I;
        pipe_d_reg[0] <= new_code;
        pipe_a_reg[0] <= ~chan_b_reg;
        for (int i = 1; i < PIPE_DEPTH; i++)
        begin
          pipe_d_reg[i] <= pipe_d_reg[i-1];
          pipe_a_reg[i] <= pipe_a_reg[i-1];
        end
        out_d_reg <= pipe_d_reg[PIPE_DEPTH-1];
        out_a_reg <= pipe_a_reg[PIPE_DEPTH-1];
      end
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      hold_reg <= SYNC_BASE + ONE_CH;
    else if (srst_evt || !LINK.hw_reset_n)
      hold_reg <= SYNC_BASE + (two_ch ? TWO_CH : ONE_CH);
    else if (fall && hold_reg != 4'h0)
      hold_reg <= hold_reg - 4'h1;
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      sync_n_reg <= 1'b1;
    // Channel A marker, quiet with one channel
    else
      sync_n_reg <= ~(two_ch & out_a_reg & (hold_reg == 4'h0));
  end

  // Bus enable lags the strobe by one clock; host samples late enough
  always_ff @(posedge CLOCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      dev_oe_reg <= 1'b0;
      dev_d_reg <= '0;
    end
    else
    begin
      dev_oe_reg <= rd_act;
      dev_d_reg <= fmt(out_d_reg, cr1_reg[CR1_TWOS]);
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      REF_EXT_O <= 1'b0;
      POWER_DOWN_O <= 1'b0;
      DIFF_MODE_O <= 1'b0;
      TWO_CH_O <= 1'b0;
    end
    else
    begin
      REF_EXT_O <= cr0_reg[CR0_VREF];
      POWER_DOWN_O <= cr0_reg[CR0_PD];
      DIFF_MODE_O <= cr0_reg[CR0_DIFF0];
      TWO_CH_O <= two_ch;
    end
  end

  assign LINK.dev_oe = dev_oe_reg;
  assign LINK.dev_d = dev_d_reg;
  assign LINK.sync_n = sync_n_reg;
endmodule

// ---- logic/adc_host.sv ----
// Host end: AXI4-Lite command registers, bus access sequencer, clock divider
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module adc_host
  import adc_link_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  adc_link_if.host LINK,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WRITE = 4'b0010,
    ST_WHOLD = 4'b0100,
    ST_READ = 4'b1000
  } state_e;

  state_e state_reg;
  logic [7:0] aw_addr_reg;
  logic aw_got_reg;
  logic [31:0] w_data_reg;
  logic w_got_reg;
  logic [1:0] mode_reg;
  logic init_done_reg;
  logic [DATA_W-1:0] cmd_reg;
  logic [DATA_W-1:0] rd_data_reg;
  logic rd_sync_reg;
  logic [2:0] cnt_reg;
  logic [2:0] div_reg;
  logic conv_reg;
  logic go_wr;
  logic go_rd;
  logic do_wr;
  logic wr_ok;

  assign do_wr = aw_got_reg & w_got_reg & ~S_AXI_BVALID;
  assign go_wr = do_wr && aw_addr_reg == OFS_WRITE && state_reg == ST_IDLE;
  // No read before the configuring write
  assign go_rd = do_wr && aw_addr_reg == OFS_READ && state_reg == ST_IDLE &&
                 init_done_reg;
  assign wr_ok = go_wr | go_rd | (aw_addr_reg == OFS_MODE);

  always_ff @(posedge CLOCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
      mode_reg <= '0;
    end
    else
    begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_addr_reg <= S_AXI_AWADDR;
        aw_got_reg <= 1'b1;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_data_reg <= S_AXI_WDATA;
        w_got_reg <= 1'b1;
        S_AXI_WREADY <= 1'b0;
      end
      if (do_wr)
      begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        if (aw_addr_reg == OFS_MODE)
          mode_reg <= w_data_reg[1:0];
      end
      else if (S_AXI_BVALID && S_AXI_BREADY)
      begin
        S_AXI_BVALID <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= '0;
      S_AXI_RRESP <= RESP_OKAY;
    end
    else if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP <= RESP_OKAY;
      if (S_AXI_ARADDR == OFS_MODE)
        S_AXI_RDATA <= {30'h0, mode_reg};
      else if (S_AXI_ARADDR == OFS_STATUS)
        S_AXI_RDATA <= {30'h0, init_done_reg, state_reg != ST_IDLE};
      else if (S_AXI_ARADDR == OFS_DATA)
        S_AXI_RDATA <= {19'h0, rd_sync_reg, rd_data_reg};
      else
      begin
        S_AXI_RDATA <= '0;
        S_AXI_RRESP <= RESP_SLVERR;
      end
    end
    else if (S_AXI_RVALID && S_AXI_RREADY)
    begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // Bus sequencer; a command that finds it busy is refused with SLVERR
  always_ff @(posedge CLOCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      cmd_reg <= '0;
      init_done_reg <= 1'b0;
      rd_data_reg <= '0;
      rd_sync_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          cnt_reg <= STROBE_CNT;
          if (go_wr)
          begin
            // Host places register select on top bits
            cmd_reg <= w_data_reg[DATA_W-1:0];
            state_reg <= ST_WRITE;
          end
          else if (go_rd)
            state_reg <= ST_READ;
        end
        ST_WRITE:
        begin
          cnt_reg <= cnt_reg - CNT_ONE;
          if (cnt_reg == CNT_ONE)
            state_reg <= ST_WHOLD;
        end
        ST_WHOLD:
        begin
          init_done_reg <= 1'b1;
          state_reg <= ST_IDLE;
        end
        ST_READ:
        begin
          cnt_reg <= cnt_reg - CNT_ONE;
          if (cnt_reg == CNT_ONE)
          begin
            rd_data_reg <= LINK.bus;
            rd_sync_reg <= ~LINK.sync_n;
            state_reg <= ST_IDLE;
          end
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      div_reg <= '0;
      conv_reg <= 1'b0;
    end
    else if (div_reg == CONV_HALF_CNT - CNT_ONE)
    begin
      div_reg <= '0;
      conv_reg <= ~conv_reg;
    end
    else
      div_reg <= div_reg + CNT_ONE;
  end

  assign LINK.conversion_clock = conv_reg;
  // Both selects asserted for any access
  assign LINK.sel_low_n = ~(state_reg == ST_WRITE || state_reg == ST_READ);
  assign LINK.sel_high = state_reg == ST_WRITE || state_reg == ST_READ;
  assign LINK.wr_n = state_reg != ST_WRITE;
  assign LINK.rd_n = ~(state_reg == ST_READ && mode_reg[MODE_WO]);
  assign LINK.hw_reset_n = ~mode_reg[MODE_HWRST];
  assign LINK.host_oe = state_reg == ST_WRITE || state_reg == ST_WHOLD;
  assign LINK.host_d = cmd_reg;
endmodule

// ---- verif/adc_link_checker.sv ----
// Concurrent checks on the converter link signals
`timescale 1ns/1ps
module adc_link_checker
  import adc_link_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire logic conversion_clock,
  input wire logic sel_low_n,
  input wire logic sel_high,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic hw_reset_n,
  input wire logic sync_n,
  input wire logic dev_oe,
  input wire logic host_oe
);
  logic rd_sel;
  assign rd_sel = !sel_low_n && sel_high && wr_n;
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RST_N_I);
  a_no_clash: assert property (!(dev_oe && host_oe))
    else $error("both ends drive the bus");
  a_oe_cause: assert property (
    dev_oe |-> $past(rd_sel) || $past(rd_sel, 2))
    else $error("converter drives bus outside a read");
  a_read_answer: assert property (
    rd_sel && !rd_n ##1 rd_sel && !rd_n |-> dev_oe)
    else $error("strobed read not answered");
  a_strobe_len: assert property (
    $fell(wr_n) |-> !wr_n [*3] ##1 wr_n)
    else $error("write strobe length wrong");
  a_write_owns: assert property (
    !sel_low_n && !wr_n |-> host_oe && !dev_oe)
    else $error("write without host driving bus");
  a_write_hold: assert property (
    $rose(wr_n) && $past(!sel_low_n) |-> host_oe && sel_low_n ##1 !host_oe)
    else $error("bus hold after write wrong");
  a_conv_period: assert property (
    $rose(conversion_clock) |-> conversion_clock [*2] ##1 !conversion_clock [*2] ##1 conversion_clock)
    else $error("conversion clock not even duty");
  // Hardware reset can retime the marker, so it masks this check
  a_sync_steady: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I || !hw_reset_n)
    $changed(sync_n) |=> $stable(sync_n) [*3])
    else $error("marker changed between conversions");
  a_hw_sync: assert property (
    !hw_reset_n ##1 !hw_reset_n |=> sync_n)
    else $error("marker active during hardware reset");
endmodule

// ---- verif/tb_top.sv ----
// Testbench joining host and converter ends over the link
`timescale 1ns/1ps
module tb_top
  import adc_link_pkg::*;
;
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, lfsr, rd_val;
  logic [1:0] bresp, rresp, rsp;
  logic [DATA_W-1:0] samp_a, samp_b;
  logic ref_ext, pwr_dn, diff_md, two_ch;
  logic lat_on, two_on, freeze, seen_sync, prev_conv, prev_wr;
  logic [9:0] v;
  logic [9:0] cr0_tab [4] = '{10'h085, 10'h0a4, 10'h3fe, 10'h000};
  int error_cnt, checks, falls, first_sync;
  logic [DATA_W-1:0] hist [$];
  adc_link_if link();
  adc_dev u_adc_dev (.CLOCK_I(clk), .RST_N_I(rst_n), .LINK(link),
    .SAMPLE_A_I(samp_a), .SAMPLE_B_I(samp_b), .REF_EXT_O(ref_ext),
    .POWER_DOWN_O(pwr_dn), .DIFF_MODE_O(diff_md), .TWO_CH_O(two_ch));
  adc_host u_adc_host (.CLOCK_I(clk), .RST_N_I(rst_n), .LINK(link),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready));
  adc_link_checker u_adc_link_checker (.CLOCK_I(clk), .RST_N_I(rst_n),
    .conversion_clock(link.conversion_clock), .sel_low_n(link.sel_low_n),
    .sel_high(link.sel_high), .rd_n(link.rd_n), .wr_n(link.wr_n),
    .hw_reset_n(link.hw_reset_n), .sync_n(link.sync_n),
    .dev_oe(link.dev_oe), .host_oe(link.host_oe));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    if (error_cnt == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rd_val = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask
  task automatic cmd(input logic [11:0] w);
    axi_wr(OFS_WRITE, {20'h0, w});
    do
      axi_rd(OFS_STATUS);
    while (rd_val[0] !== 1'b0);
  endtask
  task automatic hw_rst;
    axi_wr(OFS_MODE, 32'h2);
    repeat (4) @(posedge clk);
    axi_wr(OFS_MODE, 32'h0);
    repeat (3) @(posedge clk);
  endtask
  task automatic do_read;
    axi_wr(OFS_READ, 32'h0);
    do
      axi_rd(OFS_STATUS);
    while (rd_val[0] !== 1'b0);
    axi_rd(OFS_DATA);
  endtask
  // Samples change mid-period so the converter never sees them move
  always @(posedge clk)
  begin
    prev_conv <= link.conversion_clock;
    prev_wr <= link.wr_n;
    if (prev_conv && !link.conversion_clock)
    begin
      falls <= falls + 1;
      if (lat_on && hist.size() > 5)
        check(link.dev_d, hist[hist.size()-6]);
      if (two_on && seen_sync)
        check(link.dev_d[11], link.sync_n);
      hist.push_back(samp_a);
    end
    if (!prev_conv && link.conversion_clock)
    begin
      lfsr = lfsr_next(lfsr);
      samp_a <= freeze ? 12'h5a5 : {1'b0, lfsr[10:0]};
      samp_b <= freeze ? 12'h3c3 : {1'b1, lfsr[26:16]};
    end
    if (two_on && !seen_sync && !link.sync_n)
    begin
      seen_sync <= 1'b1;
      first_sync <= falls;
    end
    if (!prev_wr && link.wr_n)
      falls <= 0;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end
  initial
  begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, samp_a, samp_b} = '0;
    {lat_on, two_on, freeze, seen_sync, prev_conv, prev_wr} = '0;
    lfsr = 32'h87d15f88;
    {error_cnt, checks, falls, first_sync} = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    axi_wr(OFS_READ, 32'h0);
    check(rsp, RESP_SLVERR);
    axi_rd(8'h14);
    check(rsp, RESP_SLVERR);
    check(rd_val, 32'h0);
    foreach (cr0_tab[i])
    begin
      v = cr0_tab[i];
      cmd({SEL_CR0, v});
      repeat (3) @(posedge clk);
      check({ref_ext, pwr_dn, diff_md, two_ch}, {v[CR0_VREF], v[CR0_PD],
        v[CR0_DIFF0], v[CR0_SCAN] & ~v[CR0_DIFF0]});
    end
    axi_rd(OFS_STATUS);
    check(rd_val[1], 1'b1);
    cmd({2'h2, 10'h3ff});
    cmd({2'h3, 10'h3ff});
    repeat (3) @(posedge clk);
    check({ref_ext, pwr_dn, diff_md, two_ch}, 4'h0);
    cmd({SEL_CR0, 10'h005});
    hw_rst();
    check({ref_ext, pwr_dn, diff_md, two_ch}, 4'h0);
    cmd({SEL_CR0, 10'h080});
    cmd({SEL_CR1, 10'h002});
    two_on = 1'b1;
    for (int j = 0; j < 400 && !seen_sync; j++)
      @(posedge clk);
    check(first_sync >= 9 && first_sync <= 10, 1'b1);
    repeat (80) @(posedge clk);
    check(two_ch, 1'b1);
    two_on = 1'b0;
    hw_rst();
    hist.delete();
    lat_on = 1'b1;
    repeat (120) @(posedge clk);
    lat_on = 1'b0;
    freeze = 1'b1;
    repeat (40) @(posedge clk);
    axi_wr(OFS_READ, 32'h0);
    axi_rd(OFS_STATUS);
    while (rd_val[0] !== 1'b0)
      axi_rd(OFS_STATUS);
    axi_rd(OFS_DATA);
    check(rd_val[11:0], 12'h5a5);
    cmd({SEL_CR1, 10'h040});
    axi_wr(OFS_MODE, 32'h1);
    axi_wr(OFS_READ, 32'h0);
    cmd(12'h000);
    axi_rd(OFS_DATA);
    check(rd_val[11:0], 12'h5a5);
    axi_wr(OFS_MODE, 32'h0);
    axi_wr(OFS_READ, 32'h0);
    cmd(12'h000);
    axi_rd(OFS_DATA);
    check(rd_val[11:0], 12'h000);
    // Twos complement flips only the top bit of the binary code
    cmd({SEL_CR1, 10'h080});
    do_read();
    check(rd_val, 32'h5a5 ^ 32'h800);
    cmd({SEL_CR0, 10'h008});
    repeat (40) @(posedge clk);
    do_read();
    check(rd_val, 32'h3c3 ^ 32'h800);
    cmd({SEL_CR0, 10'h020});
    repeat (40) @(posedge clk);
    do_read();
    check(rd_val, ((32'h5a5 - 32'h3c3) / 2 + 32'h800) ^ 32'h800);
    check({ref_ext, pwr_dn, diff_md, two_ch}, 4'h2);
    cmd({SEL_CR1, 10'h001});
    repeat (3) @(posedge clk);
    check({ref_ext, pwr_dn, diff_md, two_ch}, 4'h0);
    print_verdict();
  end
endmodule
